// file: dmac_pkg.sv
// Constants shared by the debug memory-access command handler
package dmac_pkg;
   // ------------------------------------------------------------
   // Command codes
   // ------------------------------------------------------------
   localparam logic [7:0] CMD_WR_PROG = 8'h0A;
   localparam logic [7:0] CMD_RD_PROG = 8'h0B;
   localparam logic [7:0] CMD_WR_DATA = 8'h0C;
   // ------------------------------------------------------------
   // Data values and counts
   // ------------------------------------------------------------
   localparam logic [7:0]  BLOCKED_BYTE = 8'hFF;
   localparam logic [16:0] COUNT_ZERO_MEANS = 17'h10000;
   localparam logic [16:0] COUNT_ONE = 17'h00001;
   localparam logic [15:0] ADDR_STEP = 16'h0001;
   localparam logic [7:0]  BYTE_ZERO = 8'h00;
endpackage

// file: dmac_counter.sv
// Address and remaining-byte counter for one memory-access command
`timescale 1ns/1ps
`default_nettype none
module dmac_counter
(
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        sys_rst_in,
   // Load and step controls
   input  wire logic        load_addr_hi_in,
   input  wire logic        load_addr_lo_in,
   input  wire logic        load_cnt_hi_in,
   input  wire logic        load_cnt_lo_in,
   input  wire logic        step_in,
   input  wire logic [7:0]  byte_in,
   // State
   output logic      [15:0] addr_out,
   output logic      [16:0] remain_out
);
   logic [15:0] addr_r;
   logic [15:0] addr_nxt;
   logic [16:0] remain_r;
   logic [16:0] remain_nxt;
   logic [7:0]  cnt_hi_r;
   logic [7:0]  cnt_hi_nxt;

   // Next values; a zero count becomes 65536 bytes
   always_comb
   begin
      addr_nxt   = addr_r;
      remain_nxt = remain_r;
      cnt_hi_nxt = cnt_hi_r;
      if (load_addr_hi_in)
         addr_nxt = {byte_in, addr_r[7:0]};
      if (load_addr_lo_in)
         addr_nxt = {addr_r[15:8], byte_in};
      if (load_cnt_hi_in)
         cnt_hi_nxt = byte_in;
      // R03: zero count mapping
      // R07: zero count mapping
      if (load_cnt_lo_in)
         remain_nxt = ({cnt_hi_r, byte_in} == 16'h0000) ?
                      dmac_pkg::COUNT_ZERO_MEANS :
                      {1'b0, cnt_hi_r, byte_in};
      // R04: address increments
      // R08: address increments
      if (step_in)
      begin
         addr_nxt   = addr_r + dmac_pkg::ADDR_STEP;
         remain_nxt = remain_r - dmac_pkg::COUNT_ONE;
      end
   end

   // Register stage
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         addr_r   <= 16'h0000;
         remain_r <= 17'h00000;
         cnt_hi_r <= 8'h00;
      end
      else
      begin
         addr_r   <= addr_nxt;
         remain_r <= remain_nxt;
         cnt_hi_r <= cnt_hi_nxt;
      end
   end

   assign addr_out   = addr_r;
   assign remain_out = remain_r;
endmodule
`default_nettype wire

// file: dmac_top.sv
// Debug link memory-access command handler (program/data memory)
//
// Overview of operation
// R01: Program write: code 0AH, address hi/lo, count hi/lo, then data.
// R02: Program read: code 0BH, address and count, device returns bytes.
// R03: Program read moves 1 to 65536 bytes; zero count means 65536.
// R04: Read addresses start at given address and increment per byte.
// R05: Outside debug mode or read-protected, reads return FFH.
// R06: Data write: code 0CH then address high then low byte.
// R07: Data write takes 1 to 65536 bytes; zero count means 65536.
// R08: Data write addresses start at given address, increment per byte.
// R09: Outside debug mode or read-protected, data write bytes are dropped.
// R10: Program write needs unlocked flash, debug mode, no protection.
// R11: Data write then sends count hi/lo and data bytes.
`timescale 1ns/1ps
`default_nettype none
module dmac_top
(
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        sys_rst_in,
   // Byte stream from the debug link pin receiver
   input  wire logic        rx_valid_in,
   input  wire logic [7:0]  rx_byte_in,
   output logic             rx_ready_out,
   // Byte stream to the debug link pin transmitter
   output logic             tx_valid_out,
   output logic      [7:0]  tx_byte_out,
   input  wire logic        tx_ready_in,
   // Device status
   input  wire logic        debug_mode_in,
   input  wire logic        read_protect_in,
   input  wire logic        flash_unlocked_in,
   // Program memory port
   output logic             prog_rd_out,
   output logic             prog_wr_out,
   output logic      [15:0] prog_addr_out,
   output logic      [7:0]  prog_wdata_out,
   input  wire logic [7:0]  prog_rdata_in,
   input  wire logic        prog_rvalid_in,
   // Data memory port
   output logic             data_wr_out,
   output logic      [15:0] data_addr_out,
   output logic      [7:0]  data_wdata_out,
   // Command status
   output logic             busy_out
);
   // ------------------------------------------------------------
   // Command sequencer
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR_HI, ST_ADDR_LO, ST_CNT_HI, ST_CNT_LO,
      ST_WDATA, ST_RFETCH, ST_RWAIT, ST_RSEND
   } dmac_state_e;

   dmac_state_e st_r;
   dmac_state_e st_nxt;
   logic [7:0]  cmd_r;
   logic [7:0]  cmd_nxt;
   logic [7:0]  tx_r;
   logic [7:0]  tx_nxt;
   logic        pwr_r;
   logic        pwr_nxt;
   logic        dwr_r;
   logic        dwr_nxt;
   logic        prd_r;
   logic        prd_nxt;
   logic [15:0] maddr_r;
   logic [15:0] maddr_nxt;
   logic [7:0]  wdat_r;
   logic [7:0]  wdat_nxt;
   logic        ld_ah;
   logic        ld_al;
   logic        ld_ch;
   logic        ld_cl;
   logic        step;
   logic        take;
   logic        allowed;
   logic [15:0] addr;
   logic [16:0] remain;

   // Byte accepted from the link this cycle
   assign take    = rx_valid_in && rx_ready_out;
   assign allowed = debug_mode_in && !read_protect_in;

   // Receive ready only while the sequencer expects a host byte
   assign rx_ready_out = (st_r == ST_IDLE) || (st_r == ST_ADDR_HI) ||
                         (st_r == ST_ADDR_LO) || (st_r == ST_CNT_HI) ||
                         (st_r == ST_CNT_LO) || (st_r == ST_WDATA);

   dmac_counter u_cnt
   (
      .clk_in          (clk_in),
      .sys_rst_in      (sys_rst_in),
      .load_addr_hi_in (ld_ah),
      .load_addr_lo_in (ld_al),
      .load_cnt_hi_in  (ld_ch),
      .load_cnt_lo_in  (ld_cl),
      .step_in         (step),
      .byte_in         (rx_byte_in),
      .addr_out        (addr),
      .remain_out      (remain)
   );

   // Next-state and strobe computation
   always_comb
   begin
      st_nxt    = st_r;
      cmd_nxt   = cmd_r;
      tx_nxt    = tx_r;
      pwr_nxt   = 1'b0;
      dwr_nxt   = 1'b0;
      prd_nxt   = 1'b0;
      maddr_nxt = maddr_r;
      wdat_nxt  = wdat_r;
      ld_ah     = 1'b0;
      ld_al     = 1'b0;
      ld_ch     = 1'b0;
      ld_cl     = 1'b0;
      step      = 1'b0;
      unique case (st_r)
         ST_IDLE:
            // R01: command decode
            // R02: command decode
            // R06: command decode
            if (take && (rx_byte_in == dmac_pkg::CMD_WR_PROG ||
                         rx_byte_in == dmac_pkg::CMD_RD_PROG ||
                         rx_byte_in == dmac_pkg::CMD_WR_DATA))
            begin
               cmd_nxt = rx_byte_in;
               st_nxt  = ST_ADDR_HI;
            end
         ST_ADDR_HI:
            if (take)
            begin
               ld_ah  = 1'b1;
               st_nxt = ST_ADDR_LO;
            end
         ST_ADDR_LO:
            if (take)
            begin
               ld_al  = 1'b1;
               st_nxt = ST_CNT_HI;
            end
         // R11: count follows address
         ST_CNT_HI:
            if (take)
            begin
               ld_ch  = 1'b1;
               st_nxt = ST_CNT_LO;
            end
         ST_CNT_LO:
            if (take)
            begin
               ld_cl  = 1'b1;
               st_nxt = (cmd_r == dmac_pkg::CMD_RD_PROG) ? ST_RFETCH
                                                          : ST_WDATA;
            end
         ST_WDATA:
            if (take)
            begin
               step      = 1'b1;
               maddr_nxt = addr;
               wdat_nxt  = rx_byte_in;
               // R10: program write gating
               if (cmd_r == dmac_pkg::CMD_WR_PROG)
                  pwr_nxt = allowed && flash_unlocked_in;
               // R09: data write gating
               else
                  dwr_nxt = allowed;
               if (remain == dmac_pkg::COUNT_ONE)
                  st_nxt = ST_IDLE;
            end
         ST_RFETCH:
         begin
            maddr_nxt = addr;
            // R05: blocked read returns FFH
            if (allowed)
            begin
               prd_nxt = 1'b1;
               st_nxt  = ST_RWAIT;
            end
            else
            begin
               tx_nxt = dmac_pkg::BLOCKED_BYTE;
               st_nxt = ST_RSEND;
            end
         end
         ST_RWAIT:
            if (prog_rvalid_in)
            begin
               tx_nxt = prog_rdata_in;
               st_nxt = ST_RSEND;
            end
         ST_RSEND:
            // R02: return data bytes
            if (tx_ready_in)
            begin
               step   = 1'b1;
               st_nxt = (remain == dmac_pkg::COUNT_ONE) ? ST_IDLE
                                                        : ST_RFETCH;
            end
         default:
            st_nxt = ST_IDLE;
      endcase
   end

   // Register stage
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         st_r    <= ST_IDLE;
         cmd_r   <= dmac_pkg::BYTE_ZERO;
         tx_r    <= dmac_pkg::BYTE_ZERO;
         pwr_r   <= 1'b0;
         dwr_r   <= 1'b0;
         prd_r   <= 1'b0;
         maddr_r <= 16'h0000;
         wdat_r  <= dmac_pkg::BYTE_ZERO;
      end
      else
      begin
         st_r    <= st_nxt;
         cmd_r   <= cmd_nxt;
         tx_r    <= tx_nxt;
         pwr_r   <= pwr_nxt;
         dwr_r   <= dwr_nxt;
         prd_r   <= prd_nxt;
         maddr_r <= maddr_nxt;
         wdat_r  <= wdat_nxt;
      end
   end

   // Outputs; memory strobes are one-cycle registered pulses
   assign tx_valid_out   = (st_r == ST_RSEND);
   assign tx_byte_out    = tx_r;
   assign prog_rd_out    = prd_r;
   assign prog_wr_out    = pwr_r;
   assign prog_addr_out  = maddr_r;
   assign prog_wdata_out = wdat_r;
   assign data_wr_out    = dwr_r;
   assign data_addr_out  = maddr_r;
   assign data_wdata_out = wdat_r;
   assign busy_out       = (st_r != ST_IDLE);
endmodule
`default_nettype wire

// file: dmac_assertions.sv
// Port checker for the memory-access command handler
`timescale 1ns/1ps
`default_nettype none
module dmac_assertions
(
   // Watched ports
   input wire logic        clk_in,
   input wire logic        sys_rst_in,
   input wire logic        rx_valid_in,
   input wire logic [7:0]  rx_byte_in,
   input wire logic        rx_ready_out,
   input wire logic        tx_valid_out,
   input wire logic [7:0]  tx_byte_out,
   input wire logic        tx_ready_in,
   input wire logic        debug_mode_in,
   input wire logic        read_protect_in,
   input wire logic        flash_unlocked_in,
   input wire logic        prog_rd_out,
   input wire logic        prog_wr_out,
   input wire logic [7:0]  prog_rdata_in,
   input wire logic        prog_rvalid_in,
   input wire logic        data_wr_out,
   input wire logic [15:0] data_addr_out,
   input wire logic [7:0]  data_wdata_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);
   a_rd_blk_ff: assert property (
      tx_valid_out && (!debug_mode_in || read_protect_in)
      |-> tx_byte_out == 8'hFF) else $error("blocked byte not FF");
   a_rd_no_fetch: assert property (
      prog_rd_out |-> debug_mode_in && !read_protect_in)
      else $error("fetch while blocked");
   a_wr_blk_data: assert property (
      data_wr_out |-> debug_mode_in && !read_protect_in)
      else $error("data write while blocked");
   a_wr_blk_prog: assert property (
      prog_wr_out |-> debug_mode_in && !read_protect_in
      && flash_unlocked_in) else $error("program write while blocked");
   a_wr_data_src: assert property (
      data_wr_out |-> $past(rx_valid_in && rx_ready_out)
      && data_wdata_out == $past(rx_byte_in))
      else $error("data byte not the one taken");
   a_wr_addr_inc: assert property (
      data_wr_out && $past(data_wr_out)
      |-> data_addr_out == $past(data_addr_out) + 16'h0001)
      else $error("data address did not step");
   a_tx_hold: assert property (
      tx_valid_out && !tx_ready_in
      |=> tx_valid_out && $stable(tx_byte_out))
      else $error("tx byte dropped before accept");
   a_tx_from_mem: assert property (
      prog_rvalid_in |=> tx_valid_out
      && tx_byte_out == $past(prog_rdata_in))
      else $error("fetched byte not sent");
   // Main scenarios seen
   c_burst: cover property (data_wr_out ##1 data_wr_out);
   c_tx: cover property (tx_valid_out && tx_ready_in);
   c_prog: cover property (prog_wr_out);
endmodule
`default_nettype wire

// file: dmac_mem_model.sv
// Program memory model answering fetches fast or slow
`timescale 1ns/1ps
`default_nettype none
module dmac_mem_model
(
   // Clock, reset and pacing
   input  wire logic        clk_in,
   input  wire logic        sys_rst_in,
   input  wire logic        slow_in,
   // Fetch port
   input  wire logic        prog_rd_in,
   input  wire logic [15:0] prog_addr_in,
   output logic      [7:0]  prog_rdata_out,
   output logic             prog_rvalid_out
);
   logic [15:0] addr_r;
   logic [1:0]  wait_r;
   logic        pend_r;
   // Data line toggles when idle so stale bytes never pass
   always_ff @(posedge clk_in)
   begin
      prog_rvalid_out <= 1'b0;
      prog_rdata_out <= ~prog_rdata_out;
      if (sys_rst_in)
      begin
         pend_r <= 1'b0;
         prog_rdata_out <= 8'h00;
      end
      else if (prog_rd_in)
      begin
         pend_r <= 1'b1;
         addr_r <= prog_addr_in;
         wait_r <= slow_in ? 2'h3 : 2'h0;
      end
      else if (pend_r && wait_r != 2'h0)
         wait_r <= wait_r - 2'h1;
      else if (pend_r)
      begin
         pend_r <= 1'b0;
         prog_rvalid_out <= 1'b1;
         prog_rdata_out <= addr_r[7:0] ^ addr_r[15:8] ^ 8'h5A;
      end
   end
endmodule
`default_nettype wire

// file: tb.sv
// Self-checking bench for the memory-access command handler
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        clk_in, sys_rst_in, rx_valid_in, tx_ready_in, slow;
   logic        debug_mode_in, read_protect_in, flash_unlocked_in;
   logic        prog_rvalid_in, rx_ready_out, tx_valid_out;
   logic        prog_rd_out, prog_wr_out, data_wr_out, busy_out;
   logic [7:0]  rx_byte_in, prog_rdata_in, tx_byte_out;
   logic [7:0]  prog_wdata_out, data_wdata_out;
   logic [15:0] prog_addr_out, data_addr_out, addr;
   logic [25:0] exp_q[$];
   logic [25:0] got, exp;
   logic [2:0]  md[4] = '{3'h5, 3'h1, 3'h7, 3'h4};
   int          err_count, compares, cyc, seed, cut_len;
   dmac_top u_dmac_top (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .rx_valid_in(rx_valid_in), .rx_byte_in(rx_byte_in),
      .rx_ready_out(rx_ready_out), .tx_valid_out(tx_valid_out),
      .tx_byte_out(tx_byte_out), .tx_ready_in(tx_ready_in),
      .debug_mode_in(debug_mode_in), .read_protect_in(read_protect_in),
      .flash_unlocked_in(flash_unlocked_in), .prog_rd_out(prog_rd_out),
      .prog_wr_out(prog_wr_out), .prog_addr_out(prog_addr_out),
      .prog_wdata_out(prog_wdata_out), .prog_rdata_in(prog_rdata_in),
      .prog_rvalid_in(prog_rvalid_in), .data_wr_out(data_wr_out),
      .data_addr_out(data_addr_out), .data_wdata_out(data_wdata_out),
      .busy_out(busy_out));
   dmac_mem_model u_dmac_mem_model (.clk_in(clk_in),
      .sys_rst_in(sys_rst_in), .slow_in(slow), .prog_rd_in(prog_rd_out),
      .prog_addr_in(prog_addr_out), .prog_rdata_out(prog_rdata_in),
      .prog_rvalid_out(prog_rvalid_in));
   initial
   begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   task test_done;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Hand one byte over, held until taken
   task send(input logic [7:0] b);
      rx_byte_in = b;
      rx_valid_in = 1'b1;
      do @(posedge clk_in); while (rx_ready_out !== 1'b1);
      @(negedge clk_in);
   endtask
   // Header then data; expected effects noted first
   task cmd(input logic [7:0] code, input logic [15:0] a, n);
      logic [39:0] h;
      logic [7:0]  d;
      logic        ok;
      h = {code, a, n};
      ok = debug_mode_in && !read_protect_in;
      for (int i = 0; i < 5; i++)
         send(h[39-8*i -: 8]);
      for (int i = 0; i < (n == 16'h0000 ? cut_len : n); i++)
      begin
         d = 8'($random(seed));
         addr = a + 16'(i);
         if (code == 8'h0B)
            exp_q.push_back({2'h3, 16'h0000,
               ok ? addr[7:0] ^ addr[15:8] ^ 8'h5A : 8'hFF});
         else if (code == 8'h0C || flash_unlocked_in)
         begin
            if (ok)
               exp_q.push_back({code == 8'h0C ? 2'h1 : 2'h2, addr, d});
         end
         if (code != 8'h0B)
            send(d);
      end
   endtask
   // Let the command end before status moves
   task settle;
      rx_valid_in = 1'b0;
      for (int w = 0; w < 60 && busy_out !== 1'b0; w++)
         @(negedge clk_in);
      repeat (2) @(negedge clk_in);
   endtask
   // Host side and memory model pace stall at random
   always @(negedge clk_in)
   begin
      tx_ready_in <= 1'($random(seed));
      slow <= 1'($random(seed));
   end
   // Every write strobe and sent byte meets the oldest note
   always @(posedge clk_in)
   begin
      cyc++;
      if (!sys_rst_in && (data_wr_out || prog_wr_out
         || tx_valid_out && tx_ready_in))
      begin
         got = data_wr_out ? {2'h1, data_addr_out, data_wdata_out}
            : prog_wr_out ? {2'h2, prog_addr_out, prog_wdata_out}
            : {2'h3, 16'h0000, tx_byte_out};
         exp = exp_q.size() == 0 ? 26'h0 : exp_q.pop_front();
         compares++;
         if (got !== exp)
         begin
            err_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
         end
      end
      if (cyc == 80000)
      begin
         err_count++;
         $display("BAD %0t got %h exp %h", $time, cyc, 0);
         test_done;
      end
   end
   initial
   begin
      seed = 32'h0DEC;
      {rx_valid_in, rx_byte_in} = 9'h000;
      cut_len = 65536;
      {debug_mode_in, read_protect_in, flash_unlocked_in} = 3'h5;
      sys_rst_in = 1'b1;
      repeat (8) @(negedge clk_in);
      sys_rst_in = 1'b0;
      // Each command under each gating mode, back to back
      for (int m = 0; m < 4; m++)
      begin
         {debug_mode_in, read_protect_in, flash_unlocked_in} = md[m];
         addr = 16'($random(seed));
         cmd(8'h0A, addr, 16'h0003);
         cmd(8'h0B, addr, 16'h0003);
         send(8'h3C);
         cmd(8'h0C, addr, 16'h0002);
         cmd(8'h0B, 16'hFFFF, 16'h0002);
         settle;
         $display("test mode %0d done", m);
      end
      // A full 64K read is too slow; check it outlives 8 bytes, then cut it
      {debug_mode_in, read_protect_in, flash_unlocked_in} = 3'h5;
      cut_len = 8;
      cmd(8'h0B, 16'($random(seed)), 16'h0000);
      rx_valid_in = 1'b0;
      while (exp_q.size() != 0)
         @(negedge clk_in);
      cut_len = 65536;
      compares++;
      if (busy_out !== 1'b1)
      begin
         err_count++;
         $display("BAD %0t got %h exp %h", $time, busy_out, 1'b1);
      end
      sys_rst_in = 1'b1;
      repeat (2) @(negedge clk_in);
      sys_rst_in = 1'b0;
      compares++;
      if (busy_out !== 1'b0 || rx_ready_out !== 1'b1)
      begin
         err_count++;
         $display("BAD %0t got %h exp %h", $time,
            {busy_out, rx_ready_out}, 2'h1);
      end
      $display("test reset cut done");
      // Zero count moves a full 64K burst across the wrap
      cmd(8'h0C, 16'hFFF0, 16'h0000);
      settle;
      $display("test full burst done");
      if (exp_q.size() != 0)
      begin
         err_count++;
         $display("BAD %0t got %h exp %h", $time, exp_q.size(), 0);
      end
      test_done;
   end
endmodule
bind dmac_top dmac_assertions u_dmac_assertions (.clk_in(clk_in),
   .sys_rst_in(sys_rst_in), .rx_valid_in(rx_valid_in),
   .rx_byte_in(rx_byte_in), .rx_ready_out(rx_ready_out),
   .tx_valid_out(tx_valid_out), .tx_byte_out(tx_byte_out),
   .tx_ready_in(tx_ready_in), .debug_mode_in(debug_mode_in),
   .read_protect_in(read_protect_in),
   .flash_unlocked_in(flash_unlocked_in), .prog_rd_out(prog_rd_out),
   .prog_wr_out(prog_wr_out), .prog_rdata_in(prog_rdata_in),
   .prog_rvalid_in(prog_rvalid_in), .data_wr_out(data_wr_out),
   .data_addr_out(data_addr_out), .data_wdata_out(data_wdata_out));
`default_nettype wire
